// ==== inc/mba_params.svh ====
// constants for the multiprocessor bus arbitration node and its system end
`ifndef MBA_PARAMS_SVH
`define MBA_PARAMS_SVH

`define MBA_NUM_SLOTS 6
`define MBA_ID_W 3
`define MBA_SINGLE_ID 3'h0
`define MBA_PARK_SLOT 3'h1

// register word offsets on the system end (byte address is four times these)
`define MBA_REG_CTRL 2'h0
`define MBA_REG_PEER 2'h1
`define MBA_REG_STAT 2'h2

// control register fields
`define MBA_CTRL_ID_LSB 0
`define MBA_CTRL_ROT_BIT 3
`define MBA_CTRL_HOLD_BIT 4
`define MBA_CTRL_HBR_BIT 5
`define MBA_CTRL_CPA_BIT 6
`define MBA_CTRL_RST 7'h10

// status register fields
`define MBA_STAT_REQ_LSB 0
`define MBA_STAT_HBG_BIT 6
`define MBA_STAT_CPA_BIT 7
`define MBA_STAT_ID_LSB 8

`endif

// ==== inc/mba_pkg.sv ====
// types shared by the arbitration node and the system end
package mba_pkg;

	typedef enum logic [1:0] {
		MBA_ROLE_SLAVE = 2'b00,
		MBA_ROLE_MASTER = 2'b01,
		MBA_ROLE_HOST = 2'b10
	} mba_role_t;

	typedef enum logic {
		MBA_ARB_FIXED = 1'b0,
		MBA_ARB_ROTATE = 1'b1
	} mba_arb_mode_t;

endpackage

// ==== inc/mba_bus_if.sv ====
// shared multiprocessor bus wiring between one arbitration node and the system around it
`timescale 1ns/100ps
interface mba_bus_if;
	// system configuration, driven by the system end
	logic [2:0] proc_slot_id;
	logic rotate_arb_select;
	logic node_hold;
	logic host_bus_request_n;
	// request lines: each side drives per line with enable low while driving
	logic [5:0] node_br_out;
	logic [5:0] node_br_oe_n;
	logic [5:0] sys_br_out;
	logic [5:0] sys_br_oe_n;
	logic [5:0] peer_bus_req_lines_n;
	// open-drain core priority line, both sides may pull low
	logic node_cpa_oe_n;
	logic sys_cpa_oe_n;
	logic core_priority_req_n;
	// host grant, driven by the bus master node only
	logic node_hbg_out;
	logic node_hbg_oe_n;
	logic host_bus_grant_n;

	// wire resolution: undriven lines float high through pull-ups
	genvar gi;
	for (gi = 0; gi < 6; gi++) begin : g_line
		assign peer_bus_req_lines_n[gi] = !node_br_oe_n[gi] ? node_br_out[gi] :
			(!sys_br_oe_n[gi] ? sys_br_out[gi] : 1'b1);
	end
	assign core_priority_req_n = node_cpa_oe_n & sys_cpa_oe_n;
	assign host_bus_grant_n = node_hbg_oe_n ? 1'b1 : node_hbg_out;

	modport node (
		input proc_slot_id, rotate_arb_select, node_hold, host_bus_request_n,
		input peer_bus_req_lines_n, core_priority_req_n, host_bus_grant_n,
		output node_br_out, node_br_oe_n, node_cpa_oe_n, node_hbg_out, node_hbg_oe_n
	);
	modport sys (
		output proc_slot_id, rotate_arb_select, node_hold, host_bus_request_n,
		output sys_br_out, sys_br_oe_n, sys_cpa_oe_n,
		input peer_bus_req_lines_n, core_priority_req_n, host_bus_grant_n
	);
endinterface

// ==== core/mba_node.sv ====
// distributed bus arbitration node of one processor on the shared parallel bus
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "mba_params.svh"
module mba_node #(
	parameter int NUM_SLOTS = `MBA_NUM_SLOTS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	mba_bus_if.node bus,
	input wire logic core_req,
	input wire logic dma_req,
	output logic core_grant_r,
	output logic dma_grant_r,
	output logic bus_master_r,
	output logic host_granted_r,
	output logic [2:0] master_slot_r
);

	// the bus has six request lines, so at most six slots exist
	if (NUM_SLOTS < 1 || NUM_SLOTS > `MBA_NUM_SLOTS) begin : g_bad_slots
		$error("mba_node: NUM_SLOTS must lie between 1 and 6");
	end

	logic [2:0] my_id;
	logic single_mode;
	logic [5:0] req_seen;
	logic host_req;
	logic cpa_low;
	logic is_master;
	logic own_line_nxt;
	logic [2:0] winner;
	logic [2:0] mstr_nxt;
	mba_pkg::mba_arb_mode_t arb_mode;
	mba_pkg::mba_role_t role_r;
	mba_pkg::mba_role_t role_nxt;
	logic [5:0] br_drive_r;
	logic own_req_r;
	logic cpa_drive_r;
	logic hbg_drive_r;
	logic [2:0] mstr_r;

	// picks the next holder: the slot just after 'last' has top priority
	function automatic logic [2:0] pick_winner(input logic [5:0] req, input logic [2:0] last);
		logic [2:0] found;
		logic [2:0] idx;
		found = 3'h0;
		idx = last;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			idx = (idx == 3'(NUM_SLOTS)) ? 3'h1 : 3'(idx + 3'h1);
			if (found == 3'h0 && req[idx - 3'h1]) begin
				found = idx;
			end
		end
		return found;
	endfunction

	// configuration inputs come from same-clock system logic, read directly
	assign my_id = bus.proc_slot_id;
	assign single_mode = (my_id == `MBA_SINGLE_ID);
	assign arb_mode = mba_pkg::mba_arb_mode_t'(bus.rotate_arb_select);
	assign host_req = ~bus.host_bus_request_n;
	// a floating line reads high through its pull-up, so it shows as idle
	assign cpa_low = ~bus.core_priority_req_n;

	// every line is watched, own one included, so all nodes see the same set
	assign req_seen = ~bus.peer_bus_req_lines_n;

	// fixed order starts after slot six; rotating order starts after the holder
	always_comb begin
		if (arb_mode == mba_pkg::MBA_ARB_ROTATE) begin
			winner = pick_winner(req_seen, mstr_r);
		end else begin
			winner = pick_winner(req_seen, 3'(NUM_SLOTS));
		end
	end

	// the holder keeps the bus while its line is low or the host requests; otherwise the winner takes it, and with no request the holder stays
	always_comb begin
		mstr_nxt = mstr_r;
		if (host_req) begin
			mstr_nxt = mstr_r;
		end else if (!req_seen[mstr_r - 3'h1] && winner != 3'h0) begin
			mstr_nxt = winner;
		end
	end

	assign is_master = single_mode ? 1'b1 : (mstr_r == my_id);

	// background dma backs off while any slave core pulls the priority line
	assign own_line_nxt = ~single_mode & (core_req | (dma_req & ~cpa_low));

	// observed bus holder, tracked identically in every node
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mstr_r <= `MBA_PARK_SLOT;
		end else if (bus.node_hold) begin
			mstr_r <= `MBA_PARK_SLOT;
		end else begin
			mstr_r <= mstr_nxt;
		end
	end

	// request line drive: only the line named by the slot id, none when single
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			br_drive_r <= 6'h00;
			own_req_r <= 1'b0;
		end else if (bus.node_hold) begin
			br_drive_r <= 6'h00;
			own_req_r <= 1'b0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				br_drive_r[i] <= !single_mode && (my_id == 3'(i + 1)) && (i < NUM_SLOTS);
			end
			own_req_r <= own_line_nxt;
		end
	end

	genvar gi;
	for (gi = 0; gi < 6; gi++) begin : g_br
		// the own line is driven outside reset, hold and single mode, high when idle; it floats otherwise
		assign bus.node_br_oe_n[gi] = ~br_drive_r[gi];
		assign bus.node_br_out[gi] = ~own_req_r;
	end

	// a slave whose core wants the bus pulls the shared line low, never high
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cpa_drive_r <= 1'b0;
		end else if (bus.node_hold) begin
			cpa_drive_r <= 1'b0;
		end else begin
			cpa_drive_r <= ~single_mode & ~is_master & core_req;
		end
	end
	assign bus.node_cpa_oe_n = ~cpa_drive_r;

	// role of this node, kept for the bus master status output
	always_comb begin
		case (role_r)
			mba_pkg::MBA_ROLE_SLAVE: begin
				role_nxt = is_master ? (host_req ? mba_pkg::MBA_ROLE_HOST : mba_pkg::MBA_ROLE_MASTER)
					: mba_pkg::MBA_ROLE_SLAVE;
			end
			mba_pkg::MBA_ROLE_MASTER: begin
				if (host_req) begin
					role_nxt = mba_pkg::MBA_ROLE_HOST;
				end else begin
					role_nxt = is_master ? mba_pkg::MBA_ROLE_MASTER : mba_pkg::MBA_ROLE_SLAVE;
				end
			end
			mba_pkg::MBA_ROLE_HOST: begin
				// the grant stays until the host lets go of its request
				if (host_req) begin
					role_nxt = mba_pkg::MBA_ROLE_HOST;
				end else begin
					role_nxt = is_master ? mba_pkg::MBA_ROLE_MASTER : mba_pkg::MBA_ROLE_SLAVE;
				end
			end
			default: begin
				role_nxt = mba_pkg::MBA_ROLE_SLAVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			role_r <= mba_pkg::MBA_ROLE_SLAVE;
		end else if (bus.node_hold) begin
			role_r <= mba_pkg::MBA_ROLE_SLAVE;
		end else begin
			role_r <= role_nxt;
		end
	end

	// host grant is driven only by the node holding the bus when the host asks
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hbg_drive_r <= 1'b0;
		end else if (bus.node_hold) begin
			hbg_drive_r <= 1'b0;
		end else begin
			hbg_drive_r <= host_req & is_master;
		end
	end
	assign bus.node_hbg_oe_n = ~hbg_drive_r;
	assign bus.node_hbg_out = 1'b0;

	// grants to the local users; the core goes ahead of dma on this node
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_grant_r <= 1'b0;
			dma_grant_r <= 1'b0;
		end else if (bus.node_hold) begin
			core_grant_r <= 1'b0;
			dma_grant_r <= 1'b0;
		end else begin
			core_grant_r <= is_master & ~host_req & core_req;
			dma_grant_r <= is_master & ~host_req & dma_req & ~core_req & ~cpa_low;
		end
	end

	// status seen by the local processor
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_master_r <= 1'b0;
			host_granted_r <= 1'b0;
			master_slot_r <= `MBA_PARK_SLOT;
		end else begin
			bus_master_r <= (role_nxt == mba_pkg::MBA_ROLE_MASTER);
			host_granted_r <= ~bus.host_bus_grant_n;
			master_slot_r <= mstr_nxt;
		end
	end

endmodule // mba_node

// ==== core/mba_sys.sv ====
// system end: configuration straps, peer requests and host request, set over avalon-mm
`timescale 1ns/100ps
`include "mba_params.svh"
module mba_sys (
	input wire logic sys_clk,
	input wire logic sys_rst,
	mba_bus_if.sys bus,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	logic [6:0] ctrl_r;
	logic [5:0] peer_r;
	logic [2:0] id_r;
	logic rot_r;
	logic [31:0] rd_nxt;
	logic acc_fire;

	// one wait cycle per access; the write lands on the edge that ends it
	assign acc_fire = (avs_read | avs_write) & ~avs_waitrequest;

	always_comb begin
		rd_nxt = 32'h00000000;
		case (avs_address)
			`MBA_REG_CTRL: rd_nxt[6:0] = ctrl_r;
			`MBA_REG_PEER: rd_nxt[5:0] = peer_r;
			`MBA_REG_STAT: begin
				rd_nxt[`MBA_STAT_REQ_LSB +: 6] = ~bus.peer_bus_req_lines_n;
				rd_nxt[`MBA_STAT_HBG_BIT] = ~bus.host_bus_grant_n;
				rd_nxt[`MBA_STAT_CPA_BIT] = ~bus.core_priority_req_n;
				rd_nxt[`MBA_STAT_ID_LSB +: 3] = id_r;
			end
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// bus handshake: waitrequest drops for one cycle with read data ready
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if ((avs_read | avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= rd_nxt;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// software registers
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= `MBA_CTRL_RST;
			peer_r <= 6'h00;
		end else if (acc_fire && avs_write) begin
			if (avs_address == `MBA_REG_CTRL) begin
				ctrl_r <= avs_writedata[6:0];
			end
			if (avs_address == `MBA_REG_PEER) begin
				peer_r <= avs_writedata[5:0];
			end
		end
	end

	// slot id reaches the node only while it is held in reset
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			id_r <= `MBA_SINGLE_ID;
		end else if (ctrl_r[`MBA_CTRL_HOLD_BIT]) begin
			id_r <= ctrl_r[`MBA_CTRL_ID_LSB +: 3];
		end
	end

	// one flop feeds every processor, so a change hits all in one cycle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rot_r <= 1'b0;
		end else begin
			rot_r <= ctrl_r[`MBA_CTRL_ROT_BIT];
		end
	end

	assign bus.proc_slot_id = id_r;
	assign bus.rotate_arb_select = rot_r;
	assign bus.node_hold = ctrl_r[`MBA_CTRL_HOLD_BIT];
	assign bus.host_bus_request_n = ~ctrl_r[`MBA_CTRL_HBR_BIT];
	assign bus.sys_cpa_oe_n = ~ctrl_r[`MBA_CTRL_CPA_BIT];

	// peers drive only requesting lines low and never touch the node's own line;
	// idle and unused lines are left to the pull-up
	genvar gi;
	for (gi = 0; gi < 6; gi++) begin : g_peer
		assign bus.sys_br_oe_n[gi] = ~(peer_r[gi] && (id_r != 3'(gi + 1)));
		assign bus.sys_br_out[gi] = 1'b0;
	end

endmodule // mba_sys

// ==== test/mba_arb_chk.sv ====
// assertions on the shared arbitration wiring
`timescale 1ns/100ps
module mba_arb_chk (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [2:0] proc_slot_id,
	input wire logic node_hold,
	input wire logic host_bus_request_n,
	input wire logic [5:0] node_br_oe_n,
	input wire logic node_cpa_oe_n,
	input wire logic node_hbg_oe_n,
	input wire logic host_bus_grant_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// the own-line and single-node checks wait for a settled slot id, since the id is only copied while held
	AST_ONE_LINE: assert property ($onehot0(~node_br_oe_n)) else $error("node drives two lines");
	AST_OWN_LINE: assert property ((!node_hold && proc_slot_id != 3'h0)[*3] |->
		node_br_oe_n == ~(6'h01 << (proc_slot_id - 3'h1))) else $error("wrong request line");
	AST_SINGLE: assert property ((!node_hold && proc_slot_id == 3'h0)[*2] |-> &node_br_oe_n)
		else $error("single node drives a line");
	AST_HOLD_QUIET: assert property (node_hold |=> &node_br_oe_n && node_cpa_oe_n && node_hbg_oe_n)
		else $error("node drives while held");
	AST_CPA_SLAVE: assert property (!node_cpa_oe_n |-> !(&node_br_oe_n)) else $error("cpa without request");
	AST_HBG_CAUSE: assert property ($fell(host_bus_grant_n) |-> $past(!host_bus_request_n))
		else $error("grant without host request");
	AST_HBG_HELD: assert property (!host_bus_grant_n && !host_bus_request_n && !node_hold |=>
		!host_bus_grant_n) else $error("grant dropped early");
	AST_HBG_REL: assert property ($rose(host_bus_request_n) |-> ##[0:2] host_bus_grant_n)
		else $error("grant not released");
endmodule // mba_arb_chk

// ==== test/tb_multiproc_bus_arbitration_config.sv ====
// self-checking bench: arbitration node driven by its system end
`timescale 1ns/100ps
`include "mba_params.svh"
module tb_multiproc_bus_arbitration_config;
	typedef struct packed {
		logic [2:0] id;
		logic rot;
		logic [5:0] p1;
		logic [5:0] p2;
		logic core;
		logic [2:0] e_slot;
		logic e_bm;
		logic e_cg;
	} mba_row_t;
	// holder 3 drops while others request: fixed picks lowest, rotating the next after 3
	mba_row_t rows [5] = '{'{3'h6, 1'b0, 6'h04, 6'h12, 1'b0, 3'h2, 1'b0, 1'b0},
		'{3'h6, 1'b1, 6'h04, 6'h12, 1'b0, 3'h5, 1'b0, 1'b0}, '{3'h4, 1'b0, 6'h04, 6'h00, 1'b1, 3'h4, 1'b1, 1'b1},
		'{3'h2, 1'b1, 6'h04, 6'h10, 1'b1, 3'h5, 1'b0, 1'b0}, '{3'h2, 1'b0, 6'h04, 6'h10, 1'b1, 3'h2, 1'b1, 1'b1}};
	mba_row_t r;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic core_req = 1'b0;
	logic dma_req = 1'b0;
	logic [1:0] avs_address = 2'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic cg, dg, bm, hg;
	logic [2:0] ms;
	logic [31:0] rd;
	int miscompares = 0;
	int cmp_count = 0;
	mba_bus_if bus ();
	mba_node u_mba_node (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus.node), .core_req(core_req),
		.dma_req(dma_req), .core_grant_r(cg), .dma_grant_r(dg), .bus_master_r(bm), .host_granted_r(hg),
		.master_slot_r(ms));
	mba_sys u_mba_sys (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus.sys), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	mba_arb_chk u_mba_arb_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .proc_slot_id(bus.proc_slot_id),
		.node_hold(bus.node_hold), .host_bus_request_n(bus.host_bus_request_n), .node_br_oe_n(bus.node_br_oe_n),
		.node_cpa_oe_n(bus.node_cpa_oe_n), .node_hbg_oe_n(bus.node_hbg_oe_n),
		.host_bus_grant_n(bus.host_bus_grant_n));
	// 100 ns period
	always #50 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one avalon access, held until waitrequest is seen low; an edge passes before the next
	task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		// no answer time is assumed; only the watchdog ends a wait that never comes
		while (avs_waitrequest !== 1'b0) begin
			@(posedge sys_clk);
		end
		chk(32'(avs_waitrequest), 32'h0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// the whole run is a few hundred cycles
	initial begin
		#200000;
		miscompares++;
		$display("ERROR %0t watchdog", $time);
		complete_run();
	end
	// main sequence
	initial begin
		tick(4);
		sys_rst <= 1'b0;
		tick(1);
		chk(32'({ms, bm}), 32'h2);
		av(1'b0, `MBA_REG_CTRL, 32'h0);
		chk(rd, 32'h10);
		av(1'b1, 2'h3, 32'hFFFFFFFF);
		av(1'b0, 2'h3, 32'h0);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			r = rows[i];
			core_req <= 1'b0;
			av(1'b1, `MBA_REG_CTRL, {27'h0, 1'b1, r.rot, r.id});
			av(1'b1, `MBA_REG_PEER, {26'h0, r.p1});
			av(1'b1, `MBA_REG_CTRL, {27'h0, 1'b0, r.rot, r.id});
			tick(4);
			core_req <= r.core;
			tick(2);
			av(1'b1, `MBA_REG_PEER, {26'h0, r.p2});
			tick(6);
			chk(32'(ms), 32'(r.e_slot));
			chk(32'({bm, cg}), 32'({r.e_bm, r.e_cg}));
		end
		// peer request word reads back as last written
		av(1'b0, `MBA_REG_PEER, 32'h0);
		chk(rd, 32'h10);
		// slot zero owns no line and needs no arbitration
		av(1'b1, `MBA_REG_CTRL, 32'h10);
		av(1'b1, `MBA_REG_PEER, 32'h0);
		av(1'b1, `MBA_REG_CTRL, 32'h0);
		tick(4);
		chk(32'({bm, cg}), 32'h3);
		chk(32'(bus.peer_bus_req_lines_n), 32'h3F);
		// dma on slot 1 is pre-empted by a pulled core priority line
		core_req <= 1'b0;
		dma_req <= 1'b1;
		av(1'b1, `MBA_REG_CTRL, 32'h11);
		av(1'b1, `MBA_REG_CTRL, 32'h01);
		tick(4);
		chk(32'({dg, bus.core_priority_req_n}), 32'h3);
		av(1'b1, `MBA_REG_CTRL, 32'h41);
		tick(3);
		chk(32'({dg, bus.core_priority_req_n}), 32'h0);
		// host request takes the bus from the master; the id field changes without hold and must not apply
		av(1'b1, `MBA_REG_CTRL, 32'h23);
		tick(3);
		chk(32'({hg, bm, bus.host_bus_grant_n}), 32'h4);
		// status: applied id 1, grant seen, own line 1 active from dma, no core priority pull
		av(1'b0, `MBA_REG_STAT, 32'h0);
		chk(rd, 32'h141);
		av(1'b1, `MBA_REG_CTRL, 32'h01);
		tick(3);
		chk(32'({hg, bus.host_bus_grant_n}), 32'h1);
		// second reset in mid-run
		sys_rst <= 1'b1;
		tick(2);
		chk(32'({ms, bm, dg}), 32'h4);
		sys_rst <= 1'b0;
		tick(2);
		// node still held after release: parked holder, no grants, no host grant
		chk(32'({ms, dg, cg, hg}), 32'h8);
		av(1'b0, `MBA_REG_CTRL, 32'h0);
		chk(rd, 32'h10);
		complete_run();
	end
endmodule // tb_multiproc_bus_arbitration_config
